// file: lbr_checker.sv
`timescale 1ns/1ps
module lbr_checker (
  input wire logic                 CLK, RST_N,
  input wire lbr_pkg::lbr_event_t  EVENT,
  input wire lbr_pkg::lbr_access_t ACCESS,
  input wire logic [3:0]           BP_MATCH, PERF_EVENT, BP_PIN_N,
  input wire logic [31:0]          RDATA,
  input wire logic                 RVALID, BRANCH_STEP, TRACE_ENABLE
);
  import lbr_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire logic ok_wr = ACCESS.wr && ACCESS.sel == LBR_SEL_CONTROL &&
                     (ACCESS.cpl == LBR_RING0 || ACCESS.real_mode);
  a_read_pulse: assert property (ACCESS.rd |=> RVALID)
    else $error("read not answered");
  a_no_read: assert property (!ACCESS.rd |=> !RVALID && $stable(RDATA))
    else $error("read data moved without read");
  a_step_write: assert property (ok_wr |=> BRANCH_STEP == $past(ACCESS.wdata[1]))
    else $error("branch step bit wrong");
  a_trace_write: assert property (ok_wr |=> TRACE_ENABLE == $past(ACCESS.wdata[6]))
    else $error("trace bit wrong");
  a_write_refused: assert property (ACCESS.wr && ACCESS.cpl != LBR_RING0 && !ACCESS.real_mode
    |=> $stable(BRANCH_STEP) && $stable(TRACE_ENABLE))
    else $error("unprivileged write took effect");
  a_ctrl_reserved: assert property (ACCESS.rd && ACCESS.sel == LBR_SEL_CONTROL
    |=> RDATA[31:7] == 25'h0)
    else $error("reserved control bits not zero");
  a_unmapped_zero: assert property (ACCESS.rd && ACCESS.sel > LBR_SEL_EX_TARGET
    |=> RDATA == LBR_ZERO_WORD)
    else $error("unmapped read not zero");
  a_pin_single: assert property (!BP_PIN_N[0] && !$past(PERF_EVENT[0], 3)
    |=> BP_PIN_N[0])
    else $error("breakpoint pulse longer than one cycle");
  a_pins_idle: assert property ((PERF_EVENT == 4'h0 && BP_MATCH == 4'h0) [*4]
    |-> BP_PIN_N == 4'hF)
    else $error("pin low without cause");
  cover property (ACCESS.rd ##1 RVALID);
  cover property (EVENT.intr);
  cover property ($fell(BP_PIN_N[0]));
endmodule
bind lbr_recorder lbr_checker chk_u (.CLK, .RST_N, .EVENT, .ACCESS, .BP_MATCH, .PERF_EVENT,
  .RDATA, .RVALID, .BRANCH_STEP, .TRACE_ENABLE, .BP_PIN_N);

// file: lbr_pin_watch.sv
`timescale 1ns/1ps
module lbr_pin_watch (
  input wire logic  CLK,   // Core clock
  input wire logic  RST_N, // Reset, active low
  input wire logic [3:0] PIN_N, // Watched pins
  output logic [31:0]    LOWS   // Low-cycle count per pin, one byte each
);
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N) LOWS <= 32'h0;
    else for (int i = 0; i < 4; i++) if (!PIN_N[i]) LOWS[8*i+:8] <= LOWS[8*i+:8] + 8'h1;
endmodule

// file: lbr_pkg.sv
package lbr_pkg;

  // Register selectors for the model-register access port
  localparam logic [2:0] LBR_SEL_CONTROL    = 3'h0;
  localparam logic [2:0] LBR_SEL_BR_SOURCE  = 3'h1;
  localparam logic [2:0] LBR_SEL_BR_TARGET  = 3'h2;
  localparam logic [2:0] LBR_SEL_EX_SOURCE  = 3'h3;
  localparam logic [2:0] LBR_SEL_EX_TARGET  = 3'h4;

  localparam int LBR_BIT_RECORD  = 0;
  localparam int LBR_BIT_STEP    = 1;
  localparam int LBR_BIT_PIN_LO  = 2;
  localparam int LBR_BIT_TRACE   = 6;
  localparam int LBR_NUM_PINS    = 4;
  localparam int LBR_CTRL_BITS   = 7;

  localparam logic [6:0]  LBR_CTRL_RESET = 7'h00;
  localparam logic [31:0] LBR_ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] LBR_ZERO_WORD  = 32'h0000_0000;
  localparam logic [1:0]  LBR_RING0      = 2'h0;

  typedef struct packed {
    logic       branch;     // Taken branch retires
    logic       intr;       // Interrupt or non-debug exception
    logic       dbg;        // Debug trap event
    logic [31:0] source;    // Code-segment offset of source
    logic [31:0] target;    // Code-segment offset of target
  } lbr_event_t;

  typedef struct packed {
    logic        wr;        // Model register write instruction
    logic        rd;        // Model register read instruction
    logic [2:0]  sel;
    logic [31:0] wdata;
    logic [1:0]  cpl;       // Current privilege level
    logic        real_mode;
  } lbr_access_t;

  typedef struct packed {
    logic [LBR_CTRL_BITS-1:0] ctrl;
    logic [31:0] br_source;
    logic [31:0] br_target;
    logic [31:0] ex_source;
    logic [31:0] ex_target;
    logic [31:0] rdata;
    logic        rvalid;
    logic [LBR_NUM_PINS-1:0] match_q1;
    logic [LBR_NUM_PINS-1:0] match_q2;
    logic [LBR_NUM_PINS-1:0] perf_q1;
    logic [LBR_NUM_PINS-1:0] perf_q2;
    logic [LBR_NUM_PINS-1:0] match_prev;
    logic [LBR_NUM_PINS-1:0] bp_n;
  } lbr_state_t;

endpackage

// file: lbr_recorder.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Control bit 0 enables capture of last branch and exception addresses.
// - Any debug trap clears the record enable bit in hardware.
// - Control bit 1 makes single-step trap step on branches only.
// - Control bits 2 to 5 make each pin report its breakpoint matches.
// - A breakpoint match gives one low pulse on the selected pin.
// - Unselected pins show performance events; execution is unaffected.
// - Control bit 6 enables branch trace messages.
// - With trace messages on, record registers are undefined and not maintained.
// - Control writes accepted only at privilege level 0 or real mode.
// - Taken branch loads source and target into the 32-bit branch records.
// - Interrupt or non-debug exception loads interrupted and handler addresses.
// - Interrupt first copies branch records into exception records.
// - All records hold code-segment offsets, not linear addresses.
// - Recording covers taken branches, non-debug exceptions and serviced interrupts.
// - Debug trap leaves all four records untouched.
// - Read instruction returns the four records.
module lbr_recorder (
  input  wire logic                   CLK,          // Core clock, 20 MHz
  input  wire logic                   RST_N,        // Async reset, active low
  input  wire lbr_pkg::lbr_event_t    EVENT,        // Retirement events
  input  wire lbr_pkg::lbr_access_t   ACCESS,       // Model register access
  input  wire logic [3:0]             BP_MATCH,     // Breakpoint address matches
  input  wire logic [3:0]             PERF_EVENT,   // Performance event levels
  output logic [31:0]                 RDATA,        // Read data
  output logic                        RVALID,       // Read data valid pulse
  output logic                        BRANCH_STEP,  // Step on branches only
  output logic                        TRACE_ENABLE, // Branch trace messages on
  output logic [3:0]                  BP_PIN_N      // Breakpoint pins, active low
);
  import lbr_pkg::*;

  lbr_state_t state_reg;
  lbr_state_t state_next;

  logic record_on;
  logic ctrl_write_ok;
  logic [LBR_NUM_PINS-1:0] pin_sel;
  logic [LBR_NUM_PINS-1:0] pin_level_n;

  assign record_on     = state_reg.ctrl[LBR_BIT_RECORD] &
                         ~state_reg.ctrl[LBR_BIT_TRACE];
  assign ctrl_write_ok = ACCESS.wr && (ACCESS.sel == LBR_SEL_CONTROL) &&
                         ((ACCESS.cpl == LBR_RING0) || ACCESS.real_mode);
  assign pin_sel       = state_reg.ctrl[LBR_BIT_PIN_LO +: LBR_NUM_PINS];

  // Match pulse lasts one cycle on a rising match; perf events pass as levels
  genvar gi;
  generate
    for (gi = 0; gi < LBR_NUM_PINS; gi++) begin : g_pin
      always_comb begin
        if (pin_sel[gi]) begin
          pin_level_n[gi] = ~(state_reg.match_q2[gi] & ~state_reg.match_prev[gi]);
        end else begin
          pin_level_n[gi] = ~state_reg.perf_q2[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;

    // Pins come from outside logic timing domain: two-stage sync
    state_next.match_q1   = BP_MATCH;
    state_next.match_q2   = state_reg.match_q1;
    state_next.match_prev = state_reg.match_q2;
    state_next.perf_q1    = PERF_EVENT;
    state_next.perf_q2    = state_reg.perf_q1;
    state_next.bp_n       = pin_level_n;

    if (ctrl_write_ok) begin
      state_next.ctrl = ACCESS.wdata[LBR_CTRL_BITS-1:0];
    end

    // Debug trap wins over a same-cycle write so a handler sees recording stopped
    if (EVENT.dbg) begin
      state_next.ctrl[LBR_BIT_RECORD] = 1'b0;
    end else if (record_on) begin
      if (EVENT.intr) begin
        state_next.ex_source = state_reg.br_source;
        state_next.ex_target = state_reg.br_target;
        state_next.br_source = EVENT.source;
        state_next.br_target = EVENT.target;
      end else if (EVENT.branch) begin
        state_next.br_source = EVENT.source;
        state_next.br_target = EVENT.target;
      end
    end

    if (ACCESS.rd) begin
      state_next.rvalid = 1'b1;
      case (ACCESS.sel)
        LBR_SEL_CONTROL:   state_next.rdata = {25'h0000000, state_reg.ctrl};
        LBR_SEL_BR_SOURCE: state_next.rdata = state_reg.br_source;
        LBR_SEL_BR_TARGET: state_next.rdata = state_reg.br_target;
        LBR_SEL_EX_SOURCE: state_next.rdata = state_reg.ex_source;
        LBR_SEL_EX_TARGET: state_next.rdata = state_reg.ex_target;
        default:           state_next.rdata = LBR_ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg            <= '0;
      state_reg.ctrl       <= LBR_CTRL_RESET;
      state_reg.br_source  <= LBR_ADDR_RESET;
      state_reg.br_target  <= LBR_ADDR_RESET;
      state_reg.ex_source  <= LBR_ADDR_RESET;
      state_reg.ex_target  <= LBR_ADDR_RESET;
      state_reg.bp_n       <= {LBR_NUM_PINS{1'b1}};
    end else begin
      state_reg <= state_next;
    end
  end

  assign RDATA        = state_reg.rdata;
  assign RVALID       = state_reg.rvalid;
  assign BRANCH_STEP  = state_reg.ctrl[LBR_BIT_STEP];
  assign TRACE_ENABLE = state_reg.ctrl[LBR_BIT_TRACE];
  assign BP_PIN_N     = state_reg.bp_n;

endmodule

// file: tb_lbr_recorder.sv
`timescale 1ns/1ps
module tb_lbr_recorder;
  import lbr_pkg::*;
  logic CLK = 0, RST_N = 0, rvalid, step, trace;
  lbr_event_t ev = '0;
  lbr_access_t ac = '0;
  logic [3:0] bpm = 4'h0, perf = 4'h0, pin_n;
  logic [31:0] rdata, lows, a, b, r = 32'h2ECB;
  logic [31:0] q[$];
  int fails = 0, n_tests = 0;
  always #25 CLK = ~CLK;
  lbr_recorder dut_u (.CLK, .RST_N, .EVENT(ev), .ACCESS(ac), .BP_MATCH(bpm),
    .PERF_EVENT(perf), .RDATA(rdata), .RVALID(rvalid), .BRANCH_STEP(step), .TRACE_ENABLE(trace),
    .BP_PIN_N(pin_n));
  lbr_pin_watch pw_u (.CLK, .RST_N, .PIN_N(pin_n), .LOWS(lows));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic fail(input string m);
    fails++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk_rd(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) fail("read data");
  endtask
  task automatic chk_pin(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) fail("pin low count");
  endtask
  task automatic chk_lvl(input logic [1:0] got, exp);
    n_tests++;
    if (got !== exp) fail("control level outputs");
  endtask
  // Idle cycle after each request so a strobe never drops and rises in one step
  task automatic rd(input logic [2:0] s, input logic [31:0] e);
    q.push_back(e);
    ac.sel = s;
    ac.rd = 1'b1;
    @(negedge CLK) ac.rd = 1'b0;
    @(negedge CLK);
  endtask
  task automatic wr(input logic [31:0] d, input logic [1:0] p, input logic rm);
    ac = '{wr: 1'b1, rd: 1'b0, sel: LBR_SEL_CONTROL, wdata: d, cpl: p, real_mode: rm};
    @(negedge CLK) ac.wr = 1'b0;
    @(negedge CLK);
  endtask
  task automatic evt(input logic [2:0] k, input logic [31:0] s, t);
    {ev.branch, ev.intr, ev.dbg} = k;
    ev.source = s;
    ev.target = t;
    @(negedge CLK) ev = '0;
    @(negedge CLK);
  endtask
  task automatic finish_test;
    if (q.size() != 0) fail("read answer missing");
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(negedge CLK) if (RST_N && rvalid === 1'b1) begin
    if (q.size() == 0) fail("unexpected read answer");
    else chk_rd(rdata, q.pop_front());
  end
  initial begin
    repeat (2) @(negedge CLK);
    RST_N = 1'b1;
    for (int s = 0; s < 8; s++) rd(s[2:0], 32'h0);
    wr(32'hFFFF_FFFF, 2'h3, 1'b0); rd(3'h0, 32'h0);
    wr(32'hFFFF_FF83, 2'h3, 1'b1); rd(3'h0, 32'h3);
    chk_lvl({trace, step}, 2'b01);
    wr(32'h1, 2'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r); a = r; b = ~r;
      evt(3'h4, a, b); rd(3'h1, a); rd(3'h2, b);
    end
    r = lfsr(r);
    evt(3'h2, r, 32'h100); rd(3'h3, a); rd(3'h4, b);
    rd(3'h1, r); rd(3'h2, 32'h100);
    evt(3'h1, 32'h7, 32'h8); rd(3'h0, 32'h0);
    evt(3'h4, 32'h5, 32'h6); rd(3'h1, r); rd(3'h3, a);
    wr(32'h1, 2'h0, 1'b0);
    evt(3'h4, 32'h9, 32'hA); rd(3'h1, 32'h9);
    wr(32'h44, 2'h0, 1'b0);
    chk_lvl({trace, step}, 2'b10);
    bpm = 4'h1; perf = 4'h2;
    repeat (5) @(negedge CLK);
    bpm = 4'h0; perf = 4'h0;
    repeat (5) @(negedge CLK);
    chk_pin(lows[7:0], 8'h1);
    chk_pin(lows[15:8], 8'h5);
    finish_test;
  end
endmodule
